/* src/ppm_pin_mux.v */
`timescale 1ns/1ps
`include "ppm_defines.vh"
// Contract
// - Port 1: eight bits, per-bit direction
// - Port 1 pull-up only for selected inputs
// - Reset puts port 1 into input
// - Port 15 switched as group to segments
// - Port 15 per-bit direction and pull-up
// - Segment mode drives segments plus key scan
// - Port 2 analog routes to chosen converter
// - Routing bit 1 sends receive to capture
// - Routing bit 0 sends receive to irq
// - Routing bit 2 gates event timer input
// - Oscillator mode resets to zero, pins inputs
// - Port 4 bit 0 is bias at quarter
// - System reset is active low
module ppm_pin_mux (
    // Clock and reset
    input wire clock,
    input wire rst,
    input wire sysReset_n,
    // Avalon-MM slave
    input wire [`PPM_ADDR_W-1:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    output reg [31:0] readdata,
    output reg waitrequest,
    // Port 1 pins
    input wire [7:0] port1PinIn,
    output reg [7:0] port1PinOut,
    output reg [7:0] port1PinOe_n,
    output reg [7:0] port1PullupEn,
    // Port 1 peripheral transmit data
    input wire txd0Data,
    input wire txd6Data,
    // Port 15 pins
    input wire [3:0] port15PinIn,
    output reg [3:0] port15PinOut,
    output reg [3:0] port15PinOe_n,
    output reg [3:0] port15PullupEn,
    // Port 14 pins (segment only here)
    output reg [3:0] port14PinOut,
    output reg [3:0] port14PinOe_n,
    // Display driver side
    input wire [7:0] lcdColumnDrive,
    input wire [7:0] keySourceLine,
    input wire [7:0] port2Segment,
    // Port 2 pins
    input wire [7:0] port2PinIn,
    output reg [7:0] port2PinOut,
    output reg [7:0] port2PinOe_n,
    output reg [7:0] sarAnalogChannel,
    output reg [7:0] deltaSigmaInputPair,
    output reg [7:0] port2AnalogIdle,
    // Input routing
    input wire captureTimerPin,
    input wire externalIrqPin,
    input wire gatingTimerOut,
    output reg captureTimerInput,
    output reg externalIrqZero,
    output reg eventTimerEnable,
    // Clock pins and port 4 bit 0
    output reg [3:0] clockPinIsPort,
    input wire port4Bit0In,
    output reg port4Bit0Out,
    output reg port4Bit0Oe_n,
    output reg lcdBiasSupply,
    output reg keyReturnInput
);

// ****************************************************************
// Registers
// ****************************************************************
reg [7:0] port1Latch; // Port 1 output latch
reg [7:0] port1Direction; // 1 = input
reg [7:0] port1PullupSelect; // Pull-up request
reg [7:0] port1Route; // Transmit routing bits
reg [3:0] port15Latch; // Port 15 output latch
reg [3:0] port15Direction; // 1 = input
reg [3:0] port15PullupSelect; // Pull-up request
reg segmentVsPortSelect; // 1 = segment mode
reg [7:0] displayModeRegister; // Key scan enable bit
reg [7:0] port2Latch; // Port 2 output latch
reg [7:0] port2Direction; // 1 = input
reg [7:0] port2FunctionSelect; // 1 = segment output
reg [7:0] analogPortConfig; // 1 = analog
reg [7:0] sarChannelSelect; // Per-pin SAR choice
reg [7:0] deltaSigmaControl; // Per-pin delta-sigma choice
reg [7:0] inputRoutingControl; // Routing bits
reg [7:0] oscillatorModeSelect; // Clock pin modes
reg [7:0] port4Control; // Bias, latch, direction
reg [31:0] next_readdata; // Read mux
wire anyReset; // Either reset source
wire access; // Bus request present

// Either the bus reset or the device pin reset clears state
// Active-low reset
assign anyReset = rst | ~sysReset_n;
assign access = read | write;

// ****************************************************************
// Register writes
// ****************************************************************
// Writes land on the edge where waitrequest is sampled low
always @(posedge clock) begin
    if (anyReset) begin
        port1Latch <= `PPM_RST_ZERO8;
        port1Direction <= `PPM_RST_DIR8;
        port1PullupSelect <= `PPM_RST_ZERO8;
        port1Route <= `PPM_RST_ZERO8;
        port15Latch <= `PPM_RST_ZERO4;
        port15Direction <= `PPM_RST_DIR4;
        port15PullupSelect <= `PPM_RST_ZERO4;
        segmentVsPortSelect <= 1'b0;
        displayModeRegister <= `PPM_RST_ZERO8;
        port2Latch <= `PPM_RST_ZERO8;
        port2Direction <= `PPM_RST_DIR8;
        port2FunctionSelect <= `PPM_RST_ZERO8;
        analogPortConfig <= `PPM_RST_ZERO8;
        inputRoutingControl <= `PPM_RST_ZERO8;
        oscillatorModeSelect <= `PPM_RST_ZERO8;
        port4Control <= 8'h04;
    end else if (write && !waitrequest) begin
        // Address decode
        if (address == `PPM_OFF_PORT1_LATCH) begin
            port1Latch <= writedata[7:0];
        end else if (address == `PPM_OFF_PORT1_DIR) begin
            port1Direction <= writedata[7:0];
        end else if (address == `PPM_OFF_PORT1_PULLUP) begin
            port1PullupSelect <= writedata[7:0];
        end else if (address == `PPM_OFF_PORT1_ROUTE) begin
            port1Route <= writedata[7:0] & 8'h48;
        end else if (address == `PPM_OFF_P15_LATCH) begin
            port15Latch <= writedata[3:0];
        end else if (address == `PPM_OFF_P15_DIR) begin
            port15Direction <= writedata[3:0];
        end else if (address == `PPM_OFF_P15_PULLUP) begin
            port15PullupSelect <= writedata[3:0];
        end else if (address == `PPM_OFF_SEG_SEL) begin
            segmentVsPortSelect <= writedata[0];
        end else if (address == `PPM_OFF_DISP_MODE) begin
            displayModeRegister <= writedata[7:0];
        end else if (address == `PPM_OFF_P2_LATCH) begin
            port2Latch <= writedata[7:0];
        end else if (address == `PPM_OFF_P2_DIR) begin
            port2Direction <= writedata[7:0];
        end else if (address == `PPM_OFF_P2_FUNC) begin
            port2FunctionSelect <= writedata[7:0];
        end else if (address == `PPM_OFF_ANALOG_CFG) begin
            analogPortConfig <= writedata[7:0];
        end else if (address == `PPM_OFF_ROUTING) begin
            inputRoutingControl <= writedata[7:0] & 8'h07;
        end else if (address == `PPM_OFF_OSC_MODE) begin
            oscillatorModeSelect <= writedata[7:0];
        end else if (address == `PPM_OFF_P4_CTRL) begin
            port4Control <= writedata[7:0] & 8'h07;
        end
    end
end

// Converter selections are in bits 15:8 and 23:16 of the analog word
always @(posedge clock) begin
    if (anyReset) begin
        sarChannelSelect <= `PPM_RST_ZERO8;
        deltaSigmaControl <= `PPM_RST_ZERO8;
    end else if (write && !waitrequest &&
                 address == `PPM_OFF_ANALOG_CFG) begin
        sarChannelSelect <= writedata[15:8];
        deltaSigmaControl <= writedata[23:16];
    end
end

// ****************************************************************
// Read path
// ****************************************************************
// Selects the read word for the current address
always @* begin
    next_readdata = 32'h00000000;
    if (address == `PPM_OFF_PORT1_LATCH) begin
        next_readdata[7:0] = (port1Direction & port1PinIn) |
                             (~port1Direction & port1Latch);
    end else if (address == `PPM_OFF_PORT1_DIR) begin
        next_readdata[7:0] = port1Direction;
    end else if (address == `PPM_OFF_PORT1_PULLUP) begin
        next_readdata[7:0] = port1PullupSelect;
    end else if (address == `PPM_OFF_PORT1_ROUTE) begin
        next_readdata[7:0] = port1Route;
    end else if (address == `PPM_OFF_P15_LATCH) begin
        next_readdata[3:0] = (port15Direction & port15PinIn) |
                             (~port15Direction & port15Latch);
    end else if (address == `PPM_OFF_P15_DIR) begin
        next_readdata[3:0] = port15Direction;
    end else if (address == `PPM_OFF_P15_PULLUP) begin
        next_readdata[3:0] = port15PullupSelect;
    end else if (address == `PPM_OFF_SEG_SEL) begin
        next_readdata[0] = segmentVsPortSelect;
    end else if (address == `PPM_OFF_DISP_MODE) begin
        next_readdata[7:0] = displayModeRegister;
    end else if (address == `PPM_OFF_P2_LATCH) begin
        next_readdata[7:0] = (port2Direction & port2PinIn) |
                             (~port2Direction & port2Latch);
    end else if (address == `PPM_OFF_P2_DIR) begin
        next_readdata[7:0] = port2Direction;
    end else if (address == `PPM_OFF_P2_FUNC) begin
        next_readdata[7:0] = port2FunctionSelect;
    end else if (address == `PPM_OFF_ANALOG_CFG) begin
        next_readdata[23:0] = {deltaSigmaControl, sarChannelSelect,
                               analogPortConfig};
    end else if (address == `PPM_OFF_ROUTING) begin
        next_readdata[7:0] = inputRoutingControl;
    end else if (address == `PPM_OFF_OSC_MODE) begin
        next_readdata[7:0] = oscillatorModeSelect;
    end else begin
        // Port 4 control with live pin in bit 3
        next_readdata[7:0] = {4'h0, port4Bit0In, port4Control[2:0]};
    end
end

// ****************************************************************
// Bus handshake
// ****************************************************************
// One wait cycle, then a one-cycle low waitrequest answers
always @(posedge clock) begin
    if (anyReset) begin
        waitrequest <= 1'b1;
        readdata <= 32'h00000000;
    end else if (access && waitrequest) begin
        waitrequest <= 1'b0;
        readdata <= next_readdata;
    end else begin
        waitrequest <= 1'b1;
    end
end

// ****************************************************************
// Pin drive
// ****************************************************************
// Drives every pad and routing output from flip-flops
always @(posedge clock) begin : pinDrive
    integer i;
    if (anyReset) begin
        port1PinOut <= 8'h00;
        port1PinOe_n <= 8'hFF;
        port1PullupEn <= 8'h00;
        port15PinOut <= 4'h0;
        port15PinOe_n <= 4'hF;
        port15PullupEn <= 4'h0;
        port14PinOut <= 4'h0;
        port14PinOe_n <= 4'hF;
        port2PinOut <= 8'h00;
        port2PinOe_n <= 8'hFF;
        sarAnalogChannel <= 8'h00;
        deltaSigmaInputPair <= 8'h00;
        port2AnalogIdle <= 8'h00;
        captureTimerInput <= 1'b0;
        externalIrqZero <= 1'b0;
        eventTimerEnable <= 1'b0;
        clockPinIsPort <= 4'hF;
        port4Bit0Out <= 1'b0;
        port4Bit0Oe_n <= 1'b1;
        lcdBiasSupply <= 1'b0;
        keyReturnInput <= 1'b0;
    end else begin
        port1PinOe_n <= port1Direction;
        port1PinOut <= port1Latch;
        if (port1Route[`PPM_PORT1_ROUTE_TXD0]) begin
            port1PinOut[3] <= txd0Data;
        end
        if (port1Route[`PPM_PORT1_ROUTE_TXD6]) begin
            port1PinOut[6] <= txd6Data;
        end
        port1PullupEn <= port1PullupSelect & port1Direction;
        if (segmentVsPortSelect) begin
            if (displayModeRegister[`PPM_DISP_KEYSCAN]) begin
                port14PinOut <= lcdColumnDrive[3:0] | keySourceLine[3:0];
                port15PinOut <= lcdColumnDrive[7:4] | keySourceLine[7:4];
            end else begin
                port14PinOut <= lcdColumnDrive[3:0];
                port15PinOut <= lcdColumnDrive[7:4];
            end
            port14PinOe_n <= 4'h0;
            port15PinOe_n <= 4'h0;
            port15PullupEn <= 4'h0;
        end else begin
            port14PinOut <= 4'h0;
            port14PinOe_n <= 4'hF;
            port15PinOut <= port15Latch;
            port15PinOe_n <= port15Direction;
            port15PullupEn <= port15PullupSelect & port15Direction;
        end
        // Port 2 per-pin function table
        for (i = 0; i < 8; i = i + 1) begin
            sarAnalogChannel[i] <= 1'b0;
            deltaSigmaInputPair[i] <= 1'b0;
            port2AnalogIdle[i] <= 1'b0;
            port2PinOut[i] <= port2Latch[i];
            port2PinOe_n[i] <= 1'b1;
            if (port2FunctionSelect[i]) begin
                port2PinOut[i] <= port2Segment[i];
                port2PinOe_n[i] <= 1'b0;
            end else if (analogPortConfig[i]) begin
                if (port2Direction[i]) begin
                    if (sarChannelSelect[i] && !deltaSigmaControl[i]) begin
                        sarAnalogChannel[i] <= 1'b1;
                    end else if (!sarChannelSelect[i] &&
                                 deltaSigmaControl[i]) begin
                        deltaSigmaInputPair[i] <= 1'b1;
                    end else if (!sarChannelSelect[i]) begin
                        port2AnalogIdle[i] <= 1'b1;
                    end
                end
            end else begin
                port2PinOe_n[i] <= port2Direction[i];
            end
        end
        captureTimerInput <= inputRoutingControl[`PPM_ROUTE_CAPTURE] ?
                             port1PinIn[`PPM_RX_PIN] : captureTimerPin;
        externalIrqZero <= inputRoutingControl[`PPM_ROUTE_IRQ] ?
                           port1PinIn[`PPM_RX_PIN] : externalIrqPin;
        eventTimerEnable <= inputRoutingControl[`PPM_ROUTE_GATE] ?
                            gatingTimerOut : 1'b1;
        clockPinIsPort <= ~oscillatorModeSelect[3:0];
        if (port4Control[`PPM_P4_QUARTER_BIAS]) begin
            lcdBiasSupply <= 1'b1;
            port4Bit0Oe_n <= 1'b1;
            keyReturnInput <= 1'b0;
        end else begin
            lcdBiasSupply <= 1'b0;
            port4Bit0Oe_n <= port4Control[`PPM_P4_DIR];
            keyReturnInput <= port4Bit0In;
        end
        port4Bit0Out <= port4Control[`PPM_P4_LATCH];
    end
end

endmodule

/* src/ppm_defines.vh */
`ifndef PPM_DEFINES_VH
`define PPM_DEFINES_VH
// ****************************************************************
// Register word offsets (byte address = index * 4)
// ****************************************************************
`define PPM_ADDR_W 4
`define PPM_OFF_PORT1_LATCH 4'h0
`define PPM_OFF_PORT1_DIR 4'h1
`define PPM_OFF_PORT1_PULLUP 4'h2
`define PPM_OFF_PORT1_ROUTE 4'h3
`define PPM_OFF_P15_LATCH 4'h4
`define PPM_OFF_P15_DIR 4'h5
`define PPM_OFF_P15_PULLUP 4'h6
`define PPM_OFF_SEG_SEL 4'h7
`define PPM_OFF_DISP_MODE 4'h8
`define PPM_OFF_P2_LATCH 4'h9
`define PPM_OFF_P2_DIR 4'hA
`define PPM_OFF_P2_FUNC 4'hB
`define PPM_OFF_ANALOG_CFG 4'hC
`define PPM_OFF_ROUTING 4'hD
`define PPM_OFF_OSC_MODE 4'hE
`define PPM_OFF_P4_CTRL 4'hF
// ****************************************************************
// Reset values
// ****************************************************************
`define PPM_RST_DIR8 8'hFF
`define PPM_RST_DIR4 4'hF
`define PPM_RST_ZERO8 8'h00
`define PPM_RST_ZERO4 4'h0
// ****************************************************************
// Field positions
// ****************************************************************
`define PPM_PORT1_ROUTE_TXD0 3
`define PPM_PORT1_ROUTE_TXD6 6
`define PPM_ROUTE_IRQ 0
`define PPM_ROUTE_CAPTURE 1
`define PPM_ROUTE_GATE 2
`define PPM_DISP_KEYSCAN 0
`define PPM_P4_QUARTER_BIAS 0
`define PPM_P4_LATCH 1
`define PPM_P4_DIR 2
`define PPM_RX_PIN 5
`endif

/* tb/ppm_pin_mux_props.sv */
`timescale 1ns/1ps
// ****************************************
// Pin mux checker
// ****************************************
module ppm_pin_mux_props (
    // Clock and resets
    input wire clock,
    input wire rst,
    input wire sysReset_n,
    // Bus
    input wire read,
    input wire write,
    input wire waitrequest,
    // Pins
    input wire [7:0] port1PinIn,
    input wire [7:0] port1PinOe_n,
    input wire [7:0] port1PullupEn,
    input wire [7:0] port2PinOe_n,
    input wire [7:0] sarAnalogChannel,
    input wire [7:0] deltaSigmaInputPair,
    // Routing
    input wire captureTimerPin,
    input wire externalIrqPin,
    input wire gatingTimerOut,
    input wire captureTimerInput,
    input wire externalIrqZero,
    input wire eventTimerEnable,
    input wire [3:0] clockPinIsPort
);
    // Either reset source active
    wire inReset = rst | ~sysReset_n;
    wire rxLine = port1PinIn[5];
    chk_bus_answer: assert property (@(posedge clock) disable iff (inReset)
        !inReset && (read || write) && waitrequest |=> !waitrequest)
        else $error("no answer one cycle after request");
    chk_wait_single: assert property (@(posedge clock) disable iff (inReset)
        !waitrequest |=> waitrequest)
        else $error("answer held longer than one cycle");
    chk_reset_state: assert property (@(posedge clock)
        inReset |=> port1PinOe_n == 8'hFF && clockPinIsPort == 4'hF)
        else $error("pins not inputs after reset");
    chk_p1_pullup: assert property (@(posedge clock)
        disable iff (inReset) (port1PullupEn & ~port1PinOe_n) == 8'h00)
        else $error("pull-up on a driven pin");
    chk_irq_route: assert property (@(posedge clock)
        disable iff (inReset) !inReset && externalIrqPin == rxLine
        |=> externalIrqZero == $past(rxLine))
        else $error("irq input not from pin or receive line");
    chk_cap_route: assert property (@(posedge clock)
        disable iff (inReset) !inReset && captureTimerPin == rxLine
        |=> captureTimerInput == $past(rxLine))
        else $error("capture input not from pin or receive line");
    chk_gate_high: assert property (@(posedge clock)
        disable iff (inReset) !inReset && gatingTimerOut
        |=> eventTimerEnable)
        else $error("event timer blocked while gate high");
    chk_analog_excl: assert property (@(posedge clock)
        disable iff (inReset) (sarAnalogChannel & deltaSigmaInputPair) == 8'h00
        && ((sarAnalogChannel | deltaSigmaInputPair) & ~port2PinOe_n) == 8'h00)
        else $error("analog routing clashes");
endmodule
bind ppm_pin_mux ppm_pin_mux_props chk (.clock, .rst, .sysReset_n,
    .read, .write, .waitrequest, .port1PinIn, .port1PinOe_n, .port1PullupEn,
    .port2PinOe_n, .sarAnalogChannel, .deltaSigmaInputPair, .captureTimerPin,
    .externalIrqPin, .gatingTimerOut, .captureTimerInput, .externalIrqZero,
    .eventTimerEnable, .clockPinIsPort);

/* tb/ppm_board_model.sv */
`timescale 1ns/1ps
// ****************************************
// Board side of one port
// ****************************************
module ppm_board_model #(
    parameter W = 8
) (
    // Clock
    input wire clock,
    // Pad side
    input wire [W-1:0] pinOut,
    input wire [W-1:0] oe_n,
    input wire [W-1:0] pullUp,
    // Board drivers
    input wire [W-1:0] drive,
    input wire [W-1:0] value,
    // Resolved level
    output logic [W-1:0] pinIn
);
    // Floating lines wander every cycle
    logic flip = 1'b0;
    always @(posedge clock) flip <= ~flip;
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (!oe_n[i]) pinIn[i] = pinOut[i];
            else if (drive[i]) pinIn[i] = value[i];
            else if (pullUp[i]) pinIn[i] = 1'b1;
            else pinIn[i] = flip ^ i[0];
        end
    end
endmodule

/* tb/ppm_pin_mux_test.sv */
`timescale 1ns/1ps
`include "ppm_defines.vh"
// ****************************************
// Pin mux bench
// ****************************************
module ppm_pin_mux_test;
    logic clock = 0, rst = 1, sysReset_n = 1, read = 0, write = 0;
    logic [3:0] address = 4'h0;
    logic [31:0] writedata = 32'h0, rd;
    logic txd0Data = 0, txd6Data = 0, p4Drv = 0, p4Val = 0;
    logic [7:0] lcdColumnDrive = 8'h00, keySourceLine = 8'h00;
    logic [7:0] port2Segment = 8'h00, port1Val = 8'h00, port1Drv = 8'h00;
    logic [7:0] port2Val = 8'h00, port2Drv = 8'h00;
    logic [3:0] port15Val = 4'h0, port15Drv = 4'h0;
    logic captureTimerPin = 0, externalIrqPin = 0, gatingTimerOut = 0;
    wire [31:0] readdata;
    wire waitrequest, captureTimerInput, externalIrqZero, eventTimerEnable;
    wire [7:0] port1PinIn, port1PinOut, port1PinOe_n, port1PullupEn;
    wire [3:0] port15PinIn, port15PinOut, port15PinOe_n, port15PullupEn;
    wire [3:0] port14PinOut, port14PinOe_n, clockPinIsPort;
    wire [7:0] port2PinIn, port2PinOut, port2PinOe_n, sarAnalogChannel;
    wire [7:0] deltaSigmaInputPair, port2AnalogIdle;
    wire port4Bit0In, port4Bit0Out, port4Bit0Oe_n, lcdBiasSupply;
    wire keyReturnInput;
    int error_cnt = 0, samples_checked = 0, cycles = 0;
    ppm_pin_mux dut (.clock, .rst, .sysReset_n, .address, .read, .write,
        .writedata, .readdata, .waitrequest, .port1PinIn, .port1PinOut,
        .port1PinOe_n, .port1PullupEn, .txd0Data, .txd6Data, .port15PinIn,
        .port15PinOut, .port15PinOe_n, .port15PullupEn, .port14PinOut,
        .port14PinOe_n, .lcdColumnDrive, .keySourceLine, .port2Segment,
        .port2PinIn, .port2PinOut, .port2PinOe_n, .sarAnalogChannel,
        .deltaSigmaInputPair, .port2AnalogIdle, .captureTimerPin,
        .externalIrqPin, .gatingTimerOut, .captureTimerInput,
        .externalIrqZero, .eventTimerEnable, .clockPinIsPort, .port4Bit0In,
        .port4Bit0Out, .port4Bit0Oe_n, .lcdBiasSupply, .keyReturnInput);
    // Board circuitry on ports 1, 15, 2 and port 4 bit 0
    ppm_board_model #(.W(8)) b1 (.clock, .pinOut(port1PinOut),
        .oe_n(port1PinOe_n), .pullUp(port1PullupEn), .drive(port1Drv),
        .value(port1Val), .pinIn(port1PinIn));
    ppm_board_model #(.W(4)) b15 (.clock, .pinOut(port15PinOut),
        .oe_n(port15PinOe_n), .pullUp(port15PullupEn), .drive(port15Drv),
        .value(port15Val), .pinIn(port15PinIn));
    ppm_board_model #(.W(8)) b2 (.clock, .pinOut(port2PinOut),
        .oe_n(port2PinOe_n), .pullUp(8'h00), .drive(port2Drv),
        .value(port2Val), .pinIn(port2PinIn));
    ppm_board_model #(.W(1)) b4 (.clock, .pinOut(port4Bit0Out),
        .oe_n(port4Bit0Oe_n), .pullUp(1'b0), .drive(p4Drv),
        .value(p4Val), .pinIn(port4Bit0In));
    initial forever #5 clock = ~clock;
    // Hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end
    task print_verdict();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task check(input string name, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One bus access, held until waitrequest is seen low
    // Only the hang guard ends a wait that never gets its answer
    task bus(input logic [3:0] a, input logic w, input logic [31:0] d);
        address <= a;
        write <= w;
        read <= !w;
        writedata <= d;
        @(posedge clock);
        while (waitrequest !== 1'b0) @(posedge clock);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clock);
    endtask
    // Write, then let the pins follow
    task wr(input logic [3:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
        repeat (3) @(posedge clock);
    endtask
    task rdc(input logic [3:0] a, input logic [31:0] e, input string nm);
        bus(a, 1'b0, 32'h0);
        check(nm, rd, e);
    endtask
    task t_port1();
        port1Drv <= 8'hFF;
        port1Val <= 8'h3C;
        wr(`PPM_OFF_PORT1_DIR, 32'hF0);
        wr(`PPM_OFF_PORT1_LATCH, 32'hA5);
        wr(`PPM_OFF_PORT1_PULLUP, 32'hFF);
        check("port1 oe", port1PinOe_n, 8'hF0);
        check("port1 out", port1PinOut[3:0], 4'h5);
        check("port1 pull", port1PullupEn, 8'hF0);
        rdc(`PPM_OFF_PORT1_LATCH, 32'h35, "port1 read");
        port1Drv <= 8'h00;
        repeat (3) @(posedge clock);
        rdc(`PPM_OFF_PORT1_LATCH, 32'hF5, "port1 pulled");
    endtask
    task t_txd();
        // both transmit data lines are driven high before routing
        txd0Data <= 1'b1;
        txd6Data <= 1'b1;
        wr(`PPM_OFF_PORT1_ROUTE, 32'h48);
        check("txd0", port1PinOut[3], 1'b1);
        check("txd6", port1PinOut[6], 1'b1);
        // routing cleared gives the latch back
        wr(`PPM_OFF_PORT1_ROUTE, 32'h00);
        check("p13 latch", port1PinOut[3], 1'b0);
        check("p16 latch", port1PinOut[6], 1'b0);
    endtask
    task t_port15();
        wr(`PPM_OFF_P15_DIR, 32'h3);
        wr(`PPM_OFF_P15_LATCH, 32'hC);
        wr(`PPM_OFF_P15_PULLUP, 32'hF);
        check("p15 oe", port15PinOe_n, 4'h3);
        check("p15 out", port15PinOut[3:2], 2'h3);
        check("p15 pull", port15PullupEn, 4'h3);
        lcdColumnDrive <= 8'h5A;
        keySourceLine <= 8'h81;
        wr(`PPM_OFF_SEG_SEL, 32'h1);
        check("seg15", port15PinOut, 4'h5);
        check("seg15 oe", port15PinOe_n, 4'h0);
        check("seg14", port14PinOut, 4'hA);
        wr(`PPM_OFF_DISP_MODE, 32'h1);
        check("key15", port15PinOut, 4'hD);
        check("key14", port14PinOut, 4'hB);
        wr(`PPM_OFF_SEG_SEL, 32'h0);
        check("port15 back", port15PinOe_n, 4'h3);
        // Board drives the two input bits over their pull-ups
        port15Drv <= 4'h3;
        port15Val <= 4'h2;
        rdc(`PPM_OFF_P15_LATCH, 32'hE, "port15 read");
    endtask
    task t_port2();
        wr(`PPM_OFF_P2_DIR, 32'hFF);
        wr(`PPM_OFF_ANALOG_CFG, 32'h02010F);
        check("sar", sarAnalogChannel, 8'h01);
        check("dsig", deltaSigmaInputPair, 8'h02);
        check("idle", port2AnalogIdle, 8'h0C);
        wr(`PPM_OFF_ANALOG_CFG, 32'h01010F);
        check("both sar", sarAnalogChannel, 8'h00);
        check("both ds", deltaSigmaInputPair, 8'h00);
        wr(`PPM_OFF_P2_DIR, 32'hFE);
        check("analog out", port2PinOe_n[0], 1'b1);
        wr(`PPM_OFF_ANALOG_CFG, 32'h0);
        check("digital out", port2PinOe_n[0], 1'b0);
        // Output bit 0 reads its latch, not the board value
        port2Drv <= 8'hFF;
        port2Val <= 8'h97;
        rdc(`PPM_OFF_P2_LATCH, 32'h96, "port2 read");
        // Segment function takes the pin from the converters
        port2Segment <= 8'h01;
        wr(`PPM_OFF_P2_FUNC, 32'h01);
        wr(`PPM_OFF_ANALOG_CFG, 32'h000101);
        check("seg sar", sarAnalogChannel[0], 1'b0);
        check("seg pin", {port2PinOe_n[0], port2PinOut[0]}, 2'b01);
    endtask
    task t_route();
        port1Drv <= 8'h20;
        port1Val <= 8'h20;
        for (int i = 0; i < 3; i++) begin
            wr(`PPM_OFF_ROUTING, 32'h1 << i);
            check("capture", captureTimerInput, i == 1);
            check("irq", externalIrqZero, i == 0);
            check("gate", eventTimerEnable, i != 2);
        end
        // Pins win when not routed; gate follows the gating timer
        captureTimerPin <= 1'b1;
        externalIrqPin <= 1'b1;
        gatingTimerOut <= 1'b1;
        port1Val <= 8'h00;
        repeat (3) @(posedge clock);
        check("gate on", eventTimerEnable, 1'b1);
        check("cap pin", captureTimerInput, 1'b1);
        check("irq pin", externalIrqZero, 1'b1);
        port1Val <= 8'h20;
        wr(`PPM_OFF_ROUTING, 32'h3);
        check("rx", {captureTimerInput, externalIrqZero}, 2'b11);
    endtask
    task t_bias();
        wr(`PPM_OFF_P4_CTRL, 32'h1);
        check("bias", lcdBiasSupply, 1'b1);
        check("bias oe", port4Bit0Oe_n, 1'b1);
        wr(`PPM_OFF_P4_CTRL, 32'h2);
        check("bias off", lcdBiasSupply, 1'b0);
        check("p40 out", {port4Bit0Oe_n, port4Bit0Out}, 2'b01);
        // Board drives the pin high while it is an input
        p4Drv <= 1'b1;
        p4Val <= 1'b1;
        wr(`PPM_OFF_P4_CTRL, 32'h4);
        check("key in", keyReturnInput, 1'b1);
        rdc(`PPM_OFF_P4_CTRL, 32'hC, "p40 read");
        wr(`PPM_OFF_P4_CTRL, 32'h5);
        check("key off", keyReturnInput, 1'b0);
    endtask
    task t_osc();
        wr(`PPM_OFF_OSC_MODE, 32'h5);
        check("clk pins", clockPinIsPort, 4'hA);
        sysReset_n <= 1'b0;
        repeat (2) @(posedge clock);
        sysReset_n <= 1'b1;
        @(posedge clock);
        check("rst pins", clockPinIsPort, 4'hF);
        check("rst port1", port1PinOe_n, 8'hFF);
        rdc(`PPM_OFF_OSC_MODE, 32'h0, "osc");
        rdc(`PPM_OFF_PORT1_DIR, 32'hFF, "port1 dir");
    endtask
    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        check("reset oe", port1PinOe_n, 8'hFF);
        t_port1();
        t_txd();
        t_port15();
        t_port2();
        t_route();
        t_bias();
        t_osc();
        print_verdict();
    end
endmodule
